// ### btcc_pkg_lead.sv
// Purpose: Shared constants and types of the bit-test, count, clear and compare slice,
//          and the leading-run counter used by the count operation.
// Assumes: One core clock; registers reached over AXI4-Lite with 32-bit data.
// Notes:   The counter is purely combinational and is sized by its parameters.

package btcc_pkg;
  localparam int ACC_W  = 56;
  localparam int WORD_W = 24;
  localparam int EXT_W  = 8;
  localparam int ADDR_W = 8;
  localparam int RUN_W  = 6;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_OPER  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OPND  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_A_EXT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_A_MID = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_A_LOW = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_B_EXT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_B_MID = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_B_LOW = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_FLG   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STP   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MODE  = 8'h28;
  localparam logic [ADDR_W-1:0] ACC_STEP  = 8'h0C;

  // Fields of the operation register and the mode register.
  localparam int OPF_OP_LO    = 0;
  localparam int OPF_DST      = 4;
  localparam int OPF_SRC      = 5;
  localparam int OPF_S1SEL_LO = 8;
  localparam int OPF_FORM_LO  = 12;
  localparam int OPF_STKHI    = 15;
  localparam int OPF_IDX_LO   = 16;
  localparam int MODE_SIXTEEN = 0;

  // Condition register bit positions.
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_U = 4;
  localparam int CC_E = 5;
  localparam int CC_L = 6;
  localparam int CC_S = 7;

  // Reset values and operation constants.
  localparam logic [7:0]        FLG_RST   = 8'h00;
  localparam logic [WORD_W-1:0] STP_RST   = 24'h000000;
  localparam logic [31:0]       OPER_RST  = 32'h00000000;
  localparam logic [4:0]        BIT_MAX   = 5'h17;
  localparam logic [WORD_W-1:0] LBC_BIAS  = 24'h000009;
  localparam logic [1:0]        RESP_OKAY = 2'h0;
  localparam logic [1:0]        RESP_SLV  = 2'h2;

  typedef enum logic [2:0] {
    no_op                 = 3'h0,
    bit_test_op           = 3'h1,
    count_leading_bits_op = 3'h2,
    accumulator_clear_op  = 3'h3,
    compare_op            = 3'h4
  } btcc_op_t;

  typedef enum logic [1:0] {
    s1_word_reg  = 2'h0,
    s1_accum     = 2'h1,
    s1_short_imm = 2'h2,
    s1_long_imm  = 2'h3
  } btcc_s1_t;

  typedef enum logic [2:0] {
    form_ea     = 3'h0,
    form_abs    = 3'h1,
    form_io_hi  = 3'h2,
    form_io_lo  = 3'h3,
    form_direct = 3'h4
  } btcc_form_t;
endpackage : btcc_pkg

`timescale 1ns/100ps

module btcc_lead_count #(
  parameter int W  = 56,
  parameter int CW = 6
) (
  // Value scanned from its top bit downward.
  input  wire logic [W-1:0]  value,
  // Length of the run equal to the top bit.
  output logic      [CW-1:0] run
);
  if ((1 << CW) <= W)
  begin : g_bad_width
    $error("btcc_lead_count: CW too narrow for W");
  end

  always_comb
  begin
    logic hit;
    hit = 1'b0;
    run = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (!hit && value[i] == value[W-1])
        run = CW'(run + 1'b1);
      else
        hit = 1'b1;
    end
  end
endmodule : btcc_lead_count

// ### btcc_alu.sv
// Purpose: Data arithmetic slice running bit test, leading-bit count, accumulator
//          clear and compare, driven by operation words written over AXI4-Lite.
// Assumes: Software stands in for the program control unit; one operation per write.
// Notes:   Operands from memory arrive already fetched in the operand register.
// Function
// RQ1: Bit test copies operand bit n, 0 to 23, into carry; operand untouched.
// RQ2: Bit test of system stack high decrements stack pointer by one.
// RQ3: Count leading zeros if source bit 55 clear, else leading ones.
// RQ4: Scan source from bit 55 downward, counting the run equal to top bit.
// RQ5: Middle part of destination receives nine minus run length, signed.
// RQ6: Normal mode result lies from +8 down to -47.
// RQ7: Count zeroes destination low part and sign-fills its extension part.
// RQ8: All-zero source gives a count result of zero.
// RQ9: Sixteen-bit mode skips unused low bits; result from +8 to -31.
// RQ10: Count sets N from bit 47, clears V, keeps S, L, E, U, C.
// RQ11: Count sets Z only when result bits 47 to 24 are zero.
// RQ12: Clear zeroes all 56 destination bits, extension included.
// RQ13: Clear sets U and Z, clears E, N, V, keeps C, S, L.
// RQ14: Compare subtracts source one from source two; difference is discarded.
// RQ15: Source one is word register, accumulator, short or long immediate.
// RQ16: Short immediate is six unsigned bits, right aligned, upper bits zero.
// RQ17: Words sign-extend above and zero-fill below; source two used as stored.
// RQ18: Compare updates all eight condition flags by their standard meaning.
// RQ19: Condition register bits seven to zero are S L E U N Z V C.
// RQ20: Bit test accepts five operand forms with a bit index field.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps

module btcc_alu
  import btcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // AXI4-Lite write address and data.
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [btcc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read.
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [btcc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp
);
  import btcc_pkg::*;

  logic                 aw_held;
  logic                 w_held;
  logic [ADDR_W-1:0]    waddr;
  logic [31:0]          wdata;
  logic [3:0]           wstrb;
  logic [31:0]          oper;
  logic [WORD_W-1:0]    opnd;
  logic [ACC_W-1:0]     acc [2];
  logic [7:0]           flg;
  logic [WORD_W-1:0]    stack_top_pointer;
  logic                 sixteen_mode;
  logic                 wr_fire;
  logic                 wr_hit;
  logic                 op_go;
  logic [31:0]          next_oper;
  btcc_op_t             go_op;
  logic                 go_dst;
  logic                 go_src;
  btcc_s1_t             go_s1;
  btcc_form_t           go_form;
  logic                 go_stkhi;
  logic [4:0]           go_idx;
  logic                 bt_bit;
  logic                 form_ok;
  logic [ACC_W-1:0]     src_acc;
  logic [ACC_W-1:0]     s2_acc;
  logic [ACC_W-1:0]     s1_ext;
  logic [WORD_W-1:0]    s1_word;
  logic [ACC_W:0]       diff_wide;
  logic [ACC_W-1:0]     diff;
  logic                 sub_v;
  logic [RUN_W-1:0]     run_full;
  logic [RUN_W-1:0]     run_half;
  logic [WORD_W-1:0]    lbc_val;
  logic [ACC_W-1:0]     lbc_acc;
  logic [31:0]          rd_data;
  logic                 rd_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction : merge

  // Write channel: address and data are taken independently, then committed together.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      waddr   <= '0;
      wdata   <= '0;
      wstrb   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        waddr   <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        wdata  <= s_axi_wdata;
        wstrb  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  always_comb
  begin
    case (waddr)
      OFS_OPER, OFS_OPND, OFS_A_EXT, OFS_A_MID, OFS_A_LOW, OFS_B_EXT, OFS_B_MID, OFS_B_LOW,
      OFS_FLG, OFS_STP, OFS_MODE: wr_hit = 1'b1;
      default:                   wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLV;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Operation decode; a write to the operation register issues the operation.
  assign next_oper = merge(oper, wdata, wstrb);
  assign op_go     = wr_fire && waddr == OFS_OPER;
  assign go_op     = btcc_op_t'(next_oper[OPF_OP_LO +: 3]);
  assign go_dst    = next_oper[OPF_DST];
  assign go_src    = next_oper[OPF_SRC];
  assign go_s1     = btcc_s1_t'(next_oper[OPF_S1SEL_LO +: 2]);
  assign go_form   = btcc_form_t'(next_oper[OPF_FORM_LO +: 3]);
  assign go_idx    = next_oper[OPF_IDX_LO +: 5];
  // The stack-high operand exists only as a directly named register.
  assign go_stkhi  = next_oper[OPF_STKHI] && go_form == form_direct; // [RQ2]
  assign form_ok   = go_form <= form_direct; // [RQ20]
  // An index past the word top tests nothing and yields a clear carry.
  assign bt_bit    = (go_idx <= BIT_MAX) ? opnd[go_idx] : 1'b0; // [RQ1]

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      oper         <= OPER_RST;
      opnd         <= '0;
      sixteen_mode <= 1'b0;
    end
    else if (wr_fire)
    begin
      if (waddr == OFS_OPER)
        oper <= next_oper;
      if (waddr == OFS_OPND)
        opnd <= WORD_W'(merge({8'h00, opnd}, wdata, wstrb));
      if (waddr == OFS_MODE)
        sixteen_mode <= 1'(merge({31'h0, sixteen_mode}, wdata, wstrb) >> MODE_SIXTEEN);
    end
  end

  // Leading-bit count: the half-width view drops the unused low bytes of middle and low.
  assign src_acc = acc[go_src];

  btcc_lead_count #(
    .W  (ACC_W),
    .CW (RUN_W)
  ) u_run_full (
    .value (src_acc),
    .run   (run_full)
  ); // [RQ3] [RQ4]

  btcc_lead_count #(
    .W  (40),
    .CW (RUN_W)
  ) u_run_half (
    .value ({src_acc[55:32], src_acc[23:8]}),
    .run   (run_half)
  ); // [RQ9]

  always_comb
  begin
    if (src_acc == '0)
      lbc_val = '0; // [RQ8]
    else
      lbc_val = LBC_BIAS - WORD_W'(sixteen_mode ? run_half : run_full); // [RQ5] [RQ6] [RQ9]
  end
  assign lbc_acc = {{EXT_W{lbc_val[WORD_W-1]}}, lbc_val, {WORD_W{1'b0}}}; // [RQ7]

  // Compare: both sides are 56 bits, source two exactly as stored.
  assign s2_acc = acc[go_dst];
  always_comb
  begin
    case (go_s1)
      s1_short_imm: s1_word = {18'h0, opnd[5:0]}; // [RQ16]
      default:      s1_word = opnd;
    endcase
    if (go_s1 == s1_accum)
      s1_ext = acc[!go_dst]; // [RQ15]
    else
      s1_ext = {{EXT_W{s1_word[WORD_W-1]}}, s1_word, {WORD_W{1'b0}}}; // [RQ17]
  end
  assign diff_wide = {1'b0, s2_acc} - {1'b0, s1_ext}; // [RQ14]
  assign diff      = diff_wide[ACC_W-1:0];
  assign sub_v     = (s2_acc[55] ^ s1_ext[55]) & (s2_acc[55] ^ diff[55]);

  // Accumulators: software writes by part, or the issued operation.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc[0] <= '0;
      acc[1] <= '0;
    end
    else if (wr_fire && waddr >= OFS_A_EXT && waddr <= OFS_B_LOW)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (waddr == OFS_A_EXT + ADDR_W'(k) * ACC_STEP)
          acc[k][55:48] <= 8'(merge({24'h0, acc[k][55:48]}, wdata, wstrb));
        if (waddr == OFS_A_MID + ADDR_W'(k) * ACC_STEP)
          acc[k][47:24] <= WORD_W'(merge({8'h0, acc[k][47:24]}, wdata, wstrb));
        if (waddr == OFS_A_LOW + ADDR_W'(k) * ACC_STEP)
          acc[k][23:0] <= WORD_W'(merge({8'h0, acc[k][23:0]}, wdata, wstrb));
      end
    end
    else if (op_go && go_op == count_leading_bits_op)
      acc[go_dst] <= lbc_acc; // [RQ5] [RQ7]
    else if (op_go && go_op == accumulator_clear_op)
      acc[go_dst] <= '0; // [RQ12]
  end

  // Condition register, laid out S L E U N Z V C from the top.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flg <= FLG_RST;
    else if (wr_fire && waddr == OFS_FLG)
      flg <= 8'(merge({24'h0, flg}, wdata, wstrb)); // [RQ19]
    else if (op_go)
    begin
      case (go_op)
        bit_test_op:
          if (form_ok)
            flg[CC_C] <= bt_bit; // [RQ1]
        count_leading_bits_op:
        begin
          flg[CC_N] <= lbc_val[WORD_W-1]; // [RQ10]
          flg[CC_Z] <= lbc_val == '0; // [RQ11]
          flg[CC_V] <= 1'b0; // [RQ10]
        end
        accumulator_clear_op:
        begin
          flg[CC_E] <= 1'b0; // [RQ13]
          flg[CC_U] <= 1'b1;
          flg[CC_N] <= 1'b0;
          flg[CC_Z] <= 1'b1;
          flg[CC_V] <= 1'b0;
        end
        compare_op:
        begin
          flg[CC_S] <= flg[CC_S] | (diff[46] ^ diff[45]); // [RQ18]
          flg[CC_L] <= flg[CC_L] | sub_v;
          flg[CC_E] <= !(&diff[55:47] || !(|diff[55:47]));
          flg[CC_U] <= !(diff[47] ^ diff[46]);
          flg[CC_N] <= diff[55];
          flg[CC_Z] <= diff == '0;
          flg[CC_V] <= sub_v;
          flg[CC_C] <= diff_wide[ACC_W];
        end
        default:
          flg <= flg;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stack_top_pointer <= STP_RST;
    else if (wr_fire && waddr == OFS_STP)
      stack_top_pointer <= WORD_W'(merge({8'h0, stack_top_pointer}, wdata, wstrb));
    else if (op_go && go_op == bit_test_op && form_ok && go_stkhi)
      stack_top_pointer <= stack_top_pointer - 24'h000001; // [RQ2]
  end

  // Read channel: one read at a time, answered the cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_data = '0;
    case (s_axi_araddr)
      OFS_OPER:  rd_data = oper;
      OFS_OPND:  rd_data = {8'h00, opnd};
      OFS_A_EXT: rd_data = {24'h0, acc[0][55:48]};
      OFS_A_MID: rd_data = {8'h00, acc[0][47:24]};
      OFS_A_LOW: rd_data = {8'h00, acc[0][23:0]};
      OFS_B_EXT: rd_data = {24'h0, acc[1][55:48]};
      OFS_B_MID: rd_data = {8'h00, acc[1][47:24]};
      OFS_B_LOW: rd_data = {8'h00, acc[1][23:0]};
      OFS_FLG:   rd_data = {24'h0, flg};
      OFS_STP:   rd_data = {8'h00, stack_top_pointer};
      OFS_MODE:  rd_data = {31'h0, sixteen_mode};
      default:   rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLV;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks; each but AST_SUB_SHORT compares the state after an issued operation with its cause.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [ACC_W-1:0] chk_dst;
  logic             chk_bit;
  assign chk_dst = acc[oper[OPF_DST]];
  assign chk_bit = opnd[go_idx[4:0] % 5'd24];

  sequence s_bt_go;
    op_go && go_op == bit_test_op && form_ok;
  endsequence
  sequence s_lbc_go;
    op_go && go_op == count_leading_bits_op;
  endsequence
  sequence s_zac_go;
    op_go && go_op == accumulator_clear_op;
  endsequence
  sequence s_sub_go;
    op_go && go_op == compare_op;
  endsequence

  AST_BT_CARRY: assert property (s_bt_go ##0 (go_idx <= BIT_MAX) |=> // [RQ1]
    flg[CC_C] == $past(chk_bit) && $stable(opnd) && flg[7:1] == $past(flg[7:1]))
    else $error("bit test carry wrong");
  AST_BT_STACK: assert property (s_bt_go |=> // [RQ2]
    stack_top_pointer == $past(stack_top_pointer) - ($past(go_stkhi) ? 24'h000001 : 24'h000000))
    else $error("stack pointer wrong after bit test");
  AST_LBC_RANGE: assert property (s_lbc_go |=> // [RQ6] [RQ9]
    $signed(chk_dst[47:24]) <= 8 && $signed(chk_dst[47:24]) >= (sixteen_mode ? -31 : -47))
    else $error("count result out of range");
  AST_LBC_FILL: assert property (s_lbc_go |=> // [RQ7]
    chk_dst[23:0] == '0 && chk_dst[55:48] == {EXT_W{chk_dst[47]}})
    else $error("count fill wrong");
  AST_LBC_ZERO: assert property (s_lbc_go ##0 (src_acc == '0) |=> chk_dst == '0) // [RQ8]
    else $error("zero source count not zero");
  AST_LBC_TOPRUN: assert property (s_lbc_go ##0 (!sixteen_mode && src_acc[55] != src_acc[54]) |=> // [RQ3] [RQ5]
    chk_dst[47:24] == 24'h000008)
    else $error("single-bit run count wrong");
  AST_LBC_FLAGS: assert property (s_lbc_go |=> // [RQ10] [RQ11]
    flg[CC_N] == chk_dst[47] && !flg[CC_V] && flg[CC_Z] == (chk_dst[47:24] == '0) &&
    flg[7:4] == $past(flg[7:4]) && flg[CC_C] == $past(flg[CC_C]))
    else $error("count flags wrong");
  AST_ZAC: assert property (s_zac_go |=> chk_dst == '0 && // [RQ12] [RQ13]
    flg[5:1] == 5'h0A && flg[CC_C] == $past(flg[CC_C]))
    else $error("clear result or flags wrong");
  AST_SUB_NOSTORE: assert property (s_sub_go |=> $stable(acc[0]) && $stable(acc[1])) // [RQ14]
    else $error("compare wrote an accumulator");
  AST_SUB_CARRY: assert property (s_sub_go |=> // [RQ17] [RQ18]
    flg[CC_C] == ($past(s2_acc) < $past(s1_ext)) && flg[CC_Z] == ($past(s2_acc) == $past(s1_ext)))
    else $error("compare carry or zero wrong");
  AST_SUB_SHORT: assert property (s_sub_go ##0 (go_s1 == s1_short_imm) |-> // [RQ16]
    s1_ext[55:30] == '0 && s1_ext[23:0] == '0)
    else $error("short immediate not zero extended");
endmodule : btcc_alu

// ### btcc_pcu_model.sv
// Purpose: Stands in for the program control unit, issuing register writes and reads over AXI4-Lite.
// Assumes: One request at a time; every task lines itself up on a rising clock edge before driving.
// Notes:   Bready and rready rise with the request, so the answer is taken at the edge it first shows.
`timescale 1ns/100ps

module btcc_pcu_model (
  // Clock.
  input  wire logic                        clk,
  // Write channels.
  output logic                             s_axi_awvalid,
  input  wire logic                        s_axi_awready,
  output logic [btcc_pkg::ADDR_W-1:0]      s_axi_awaddr,
  output logic [2:0]                       s_axi_awprot,
  output logic                             s_axi_wvalid,
  input  wire logic                        s_axi_wready,
  output logic [31:0]                      s_axi_wdata,
  output logic [3:0]                       s_axi_wstrb,
  input  wire logic                        s_axi_bvalid,
  output logic                             s_axi_bready,
  input  wire logic [1:0]                  s_axi_bresp,
  // Read channels.
  output logic                             s_axi_arvalid,
  input  wire logic                        s_axi_arready,
  output logic [btcc_pkg::ADDR_W-1:0]      s_axi_araddr,
  output logic [2:0]                       s_axi_arprot,
  input  wire logic                        s_axi_rvalid,
  output logic                             s_axi_rready,
  input  wire logic [31:0]                 s_axi_rdata,
  input  wire logic [1:0]                  s_axi_rresp,
  // Status.
  output logic                             timed_out
);
  import btcc_pkg::*;

  localparam int WAIT_MAX = 200;

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, timed_out} = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h00000000;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wstrb  = 4'hF;
  end

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [31:0] data, output logic [1:0] resp);
    int   n;
    logic done;
    n    = 0;
    done = 1'b0;
    resp = 2'h3;
    @(posedge clk);
    s_axi_awaddr  <= addr;
    s_axi_wdata   <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done && n < WAIT_MAX)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      timed_out <= 1'b1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] addr, output logic [31:0] data, output logic [1:0] resp);
    int   n;
    logic done;
    n    = 0;
    done = 1'b0;
    data = 32'h00000000;
    resp = 2'h3;
    @(posedge clk);
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done && n < WAIT_MAX)
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
      begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      timed_out <= 1'b1;
  endtask : rd
endmodule : btcc_pcu_model

// ### tb.sv
// Purpose: Self-checking bench for the bit-test, count, clear and compare slice.
// Assumes: Expected flags are worked out by hand from the operand values written.
// Notes:   Flag bytes read as S L E U N Z V C from bit seven down.
`timescale 1ns/100ps
`define CHK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("FAIL %s expected %h seen %h", name, exp, got); end end

module tb;
  import btcc_pkg::*;

  logic                        clk, sys_rst, timed_out;
  logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0]           s_axi_awaddr, s_axi_araddr;
  logic [2:0]                  s_axi_awprot, s_axi_arprot;
  logic [31:0]                 s_axi_wdata, s_axi_rdata;
  logic [3:0]                  s_axi_wstrb;
  logic [1:0]                  s_axi_bresp, s_axi_rresp;
  int                          error_cnt, n_tests;

  btcc_alu dut (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  btcc_pcu_model pcu (.clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .timed_out);

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic put(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    pcu.wr(a, d, r);
    `CHK("write response", RESP_OKAY, r)
  endtask : put

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] xr);
    logic [31:0] d;
    logic [1:0]  r;
    pcu.rd(a, d, r);
    `CHK($sformatf("read data at %h", a), exp, d)
    `CHK($sformatf("read response at %h", a), xr, r)
  endtask : chk_rd

  task automatic t_reset_map;
    logic [1:0] r;
    chk_rd(OFS_FLG, 32'h00000000, RESP_OKAY);
    chk_rd(OFS_STP, 32'h00000000, RESP_OKAY);
    pcu.wr(8'h30, 32'h0000FFFF, r);
    `CHK("unmapped write response", RESP_SLV, r)
    chk_rd(8'h30, 32'h00000000, RESP_SLV);
  endtask : t_reset_map

  // Each form is tested with a clear bit, then a set bit, so a stuck carry shows.
  task automatic t_bit_test;
    put(OFS_OPND, 32'h00000010);
    put(OFS_OPER, 32'h0003C001);
    chk_rd(OFS_FLG, 32'h00000000, RESP_OKAY);
    chk_rd(OFS_STP, 32'h00FFFFFF, RESP_OKAY);
    for (int f = 0; f < 5; f++)
    begin
      put(OFS_OPER, 32'h00030001 | (32'(f) << 12));
      chk_rd(OFS_FLG, 32'h00000000, RESP_OKAY);
      put(OFS_OPER, 32'h00040001 | (32'(f) << 12));
      chk_rd(OFS_FLG, 32'h00000001, RESP_OKAY);
    end
    chk_rd(OFS_STP, 32'h00FFFFFF, RESP_OKAY);
    chk_rd(OFS_OPND, 32'h00000010, RESP_OKAY);
    // An index past the word top clears carry; an unknown form changes nothing.
    put(OFS_OPER, 32'h001F4001);
    chk_rd(OFS_FLG, 32'h00000000, RESP_OKAY);
    put(OFS_OPER, 32'h00045001);
    chk_rd(OFS_FLG, 32'h00000000, RESP_OKAY);
    put(OFS_OPND, 32'h00800000);
    put(OFS_OPER, 32'h00174001);
    chk_rd(OFS_FLG, 32'h00000001, RESP_OKAY);
  endtask : t_bit_test

  task automatic cnt_case(input logic [7:0] e, input logic [23:0] m, input logic [23:0] l, input logic md,
                          input logic [23:0] xm, input logic [7:0] xe, input logic [7:0] xc);
    put(OFS_MODE, {31'h00000000, md});
    put(OFS_A_EXT, {24'h000000, e});
    put(OFS_A_MID, {8'h00, m});
    put(OFS_A_LOW, {8'h00, l});
    put(OFS_B_LOW, 32'h00123456);
    put(OFS_OPER, 32'h00000012);
    chk_rd(OFS_B_MID, {8'h00, xm}, RESP_OKAY);
    chk_rd(OFS_B_EXT, {24'h000000, xe}, RESP_OKAY);
    chk_rd(OFS_B_LOW, 32'h00000000, RESP_OKAY);
    chk_rd(OFS_FLG, {24'h000000, xc}, RESP_OKAY);
  endtask : cnt_case

  task automatic t_count;
    cnt_case(8'h00, 24'h100000, 24'hABCDEF, 1'b0, 24'hFFFFFE, 8'hFF, 8'h09);
    cnt_case(8'hFF, 24'hFFFFFF, 24'hFFFFFF, 1'b0, 24'hFFFFD1, 8'hFF, 8'h09);
    cnt_case(8'h40, 24'h000000, 24'h000000, 1'b0, 24'h000008, 8'h00, 8'h01);
    cnt_case(8'h00, 24'h000000, 24'h000000, 1'b0, 24'h000000, 8'h00, 8'h05);
    cnt_case(8'h00, 24'h000000, 24'h000100, 1'b1, 24'hFFFFE2, 8'hFF, 8'h09);
    put(OFS_MODE, 32'h00000000);
  endtask : t_count

  task automatic t_clear;
    put(OFS_A_EXT, 32'h00000012);
    put(OFS_OPER, 32'h00000003);
    chk_rd(OFS_A_EXT, 32'h00000000, RESP_OKAY);
    chk_rd(OFS_A_LOW, 32'h00000000, RESP_OKAY);
    chk_rd(OFS_FLG, 32'h00000015, RESP_OKAY);
  endtask : t_clear

  task automatic cmp_case(input logic [23:0] opnd, input logic [31:0] oper, input logic [7:0] xc);
    put(OFS_OPND, {8'h00, opnd});
    put(OFS_OPER, oper);
    chk_rd(OFS_FLG, {24'h000000, xc}, RESP_OKAY);
  endtask : cmp_case

  task automatic t_compare;
    cmp_case(24'h000045, 32'h00000204, 8'h19);
    cmp_case(24'h000000, 32'h00000304, 8'h14);
    cmp_case(24'hFFFFFF, 32'h00000004, 8'h11);
    cmp_case(24'h000000, 32'h00000104, 8'h11);
    put(OFS_A_EXT, 32'h0000007F);
    put(OFS_A_MID, 32'h00FFFFFF);
    put(OFS_A_LOW, 32'h00FFFFFF);
    cmp_case(24'hFFFFFF, 32'h00000004, 8'h7B);
    cmp_case(24'h000000, 32'h00000304, 8'h70);
    cmp_case(24'h000000, 32'h00000314, 8'h58);
    chk_rd(OFS_A_LOW, 32'h00FFFFFF, RESP_OKAY);
  endtask : t_compare

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (timed_out)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    error_cnt = 0;
    n_tests   = 0;
    sys_rst   = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_map();
    t_bit_test();
    t_count();
    t_clear();
    t_compare();
    finish_test();
  end
endmodule : tb
